// ### common/rwc_pkg.sv
// Purpose: Shared constants and types for the reset and wake control block.
// Assumes: AHB-Lite register access, 32-bit words, one clock hclk.
// Notes: Operation summary below.
// Operation
// - Hardware reset input returns every register and logic element to reset state; the pin's clear skips wdet_prev_r, dph_addr_r, dph_write_r and rwc_sync.
// - After reset or wake, writes are ignored until one host read occurs.
// - When enabled, the wake output asserts on a detected wake event.
// - A wake event and wake output never take the device out of sleep.
// - In sleep, a host write cycle (select and strobe low) wakes the device.
package rwc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 3;
  localparam int CFG_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_BYTE_TEST = 8'h10;

  // Control register fields.
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_CFG_LSB = 4;
  // Configuration bits inside the stored field.
  localparam int CFG_WAKE_EN = 0;
  localparam int CFG_WAKE_POL = 1;
  localparam int CFG_WAKE_OD = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  // State register fields.
  localparam int STATE_ASLEEP = 0;
  localparam int STATE_UNLOCKED = 1;

  // Interrupt status fields.
  localparam int IRQ_WAKE_EVT = 0;
  localparam int IRQ_HOST_WAKE = 1;
  localparam int IRQ_WR_DROP = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Byte-order test pattern; the value is arbitrary.
  localparam logic [DATA_W-1:0] BYTE_TEST_VAL = 32'hA5C3_0F96;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RWC_RUN = 2'b01,
    RWC_SLEEP = 2'b10
  } rwc_pwr_t;

endpackage : rwc_pkg

// ### src/rwc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs may change at any time relative to hclk.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none
module rwc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : rwc_sync
`default_nettype wire

// ### src/rwc_top.sv
// Purpose: Reset, write-unlock and wake control with an AHB-Lite register slave.
// Assumes: Pins are asynchronous to hclk; zero-wait-state AHB-Lite bus.
// Notes: Pin-driven clears act on the third clock edge after the pin, through the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module rwc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [rwc_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [rwc_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hard_reset_in_n,
  input wire logic host_select_n,
  input wire logic host_write_strobe_n,
  input wire logic wake_detect_in,
  output logic wake_event_out,
  output logic wake_event_oe_n,
  output logic irq_out
);
  import rwc_pkg::*;

  logic hard_s;
  logic sel_s;
  logic wstb_s;
  logic wdet_s;

  rwc_sync #(.WIDTH(4), .RESET_VAL(4'hE)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({hard_reset_in_n, host_select_n, host_write_strobe_n, wake_detect_in}),
    .q({hard_s, sel_s, wstb_s, wdet_s})
  );

  // Bus pipeline and register state.
  logic dph_valid_r, dph_valid_nxt;
  logic dph_write_r, dph_write_nxt;
  logic [ADDR_W-1:0] dph_addr_r, dph_addr_nxt;
  logic [DATA_W-1:0] hrdata_r, hrdata_nxt;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt;
  logic read_seen_r, read_seen_nxt;
  logic soft_reset_request_r, soft_reset_request_nxt;
  logic wdet_prev_r, wdet_prev_nxt;
  rwc_pwr_t pwr_r, pwr_nxt;
  logic wake_out_r, wake_out_nxt;
  logic wake_oe_n_r, wake_oe_n_nxt;
  logic irq_r, irq_nxt;

  logic clr;
  logic acc;
  logic wr_req;
  logic wr_ok;
  logic wr_drop;
  logic rd_evt;
  logic host_wr;
  logic host_wake;
  logic wake_evt;
  logic wake_act;
  logic wake_lvl;
  logic [IRQ_W-1:0] w1c;

  always_comb begin
    // Hardware reset pin and soft reset share one synchronous clear path.
    clr = !hard_s || soft_reset_request_r;
    acc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    wr_req = dph_valid_r && dph_write_r;
    // Writes before the first read after reset or wake are dropped.
    wr_ok = wr_req && read_seen_r;
    wr_drop = wr_req && !read_seen_r;
    rd_evt = dph_valid_r && !dph_write_r;
    // A host write cycle is select and write strobe low together, any data.
    host_wr = !sel_s && !wstb_s;
    host_wake = (pwr_r == RWC_SLEEP) && host_wr;
    wake_evt = wdet_s && !wdet_prev_r;
    w1c = '0;
    if (wr_ok && (dph_addr_r == ADDR_IRQ_STAT)) begin
      w1c = hwdata[IRQ_W-1:0];
    end

    dph_valid_nxt = acc;
    dph_write_nxt = hwrite;
    dph_addr_nxt = haddr[ADDR_W-1:0];
    hrdata_nxt = DATA_ZERO;
    if (acc && !hwrite) begin
      unique case (haddr[ADDR_W-1:0])
        ADDR_CTRL: hrdata_nxt[CTRL_CFG_LSB +: CFG_W] = cfg_r;
        ADDR_STATE: begin
          hrdata_nxt[STATE_ASLEEP] = (pwr_r == RWC_SLEEP);
          hrdata_nxt[STATE_UNLOCKED] = read_seen_r;
        end
        ADDR_IRQ_STAT: hrdata_nxt[IRQ_W-1:0] = stat_r;
        ADDR_IRQ_MASK: hrdata_nxt[IRQ_W-1:0] = mask_r;
        ADDR_BYTE_TEST: hrdata_nxt = BYTE_TEST_VAL;
        default: hrdata_nxt = DATA_ZERO;
      endcase
    end

    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    soft_reset_request_nxt = 1'b0;
    if (wr_ok && (dph_addr_r == ADDR_CTRL)) begin
      cfg_nxt = hwdata[CTRL_CFG_LSB +: CFG_W];
      soft_reset_request_nxt = hwdata[CTRL_SOFT_RST];
    end
    if (wr_ok && (dph_addr_r == ADDR_IRQ_MASK)) begin
      mask_nxt = hwdata[IRQ_W-1:0];
    end

    // Only a host write cycle or a clear leaves sleep; wake events merely flag.
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      RWC_RUN: begin
        if (wr_ok && (dph_addr_r == ADDR_CTRL) && hwdata[CTRL_SLEEP]) begin
          pwr_nxt = RWC_SLEEP;
        end
      end
      RWC_SLEEP: begin
        if (host_wr) begin
          pwr_nxt = RWC_RUN;
        end
      end
    endcase

    // Waking locks writes again until the next read.
    read_seen_nxt = read_seen_r;
    if (host_wake) begin
      read_seen_nxt = 1'b0;
    end else if (rd_evt) begin
      read_seen_nxt = 1'b1;
    end

    // Hardware sets win over a same-cycle write-one-to-clear.
    stat_nxt = stat_r & ~w1c;
    stat_nxt[IRQ_WAKE_EVT] = stat_nxt[IRQ_WAKE_EVT] | wake_evt;
    stat_nxt[IRQ_HOST_WAKE] = stat_nxt[IRQ_HOST_WAKE] | host_wake;
    stat_nxt[IRQ_WR_DROP] = stat_nxt[IRQ_WR_DROP] | wr_drop;
    wdet_prev_nxt = wdet_s;

    if (clr) begin
      hrdata_nxt = DATA_ZERO;
      cfg_nxt = CFG_RESET;
      mask_nxt = IRQ_RESET;
      stat_nxt = IRQ_RESET;
      soft_reset_request_nxt = 1'b0;
      pwr_nxt = RWC_RUN;
      read_seen_nxt = 1'b0;
      // A read taken during the clear must not count as the unlocking read.
      dph_valid_nxt = 1'b0;
    end

    // Wake output follows the pending wake event when enabled.
    wake_act = cfg_nxt[CFG_WAKE_EN] && stat_nxt[IRQ_WAKE_EVT];
    wake_lvl = cfg_nxt[CFG_WAKE_POL] ? wake_act : !wake_act;
    // Open drain only ever pulls low; push-pull always drives.
    if (cfg_nxt[CFG_WAKE_OD]) begin
      wake_out_nxt = 1'b0;
      wake_oe_n_nxt = wake_lvl;
    end else begin
      wake_out_nxt = wake_lvl;
      wake_oe_n_nxt = 1'b0;
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= '0;
      hrdata_r <= DATA_ZERO;
      cfg_r <= CFG_RESET;
      stat_r <= IRQ_RESET;
      mask_r <= IRQ_RESET;
      read_seen_r <= 1'b0;
      soft_reset_request_r <= 1'b0;
      wdet_prev_r <= 1'b0;
      pwr_r <= RWC_RUN;
      wake_out_r <= 1'b1;
      wake_oe_n_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      dph_valid_r <= dph_valid_nxt;
      dph_write_r <= dph_write_nxt;
      dph_addr_r <= dph_addr_nxt;
      hrdata_r <= hrdata_nxt;
      cfg_r <= cfg_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      read_seen_r <= read_seen_nxt;
      soft_reset_request_r <= soft_reset_request_nxt;
      wdet_prev_r <= wdet_prev_nxt;
      pwr_r <= pwr_nxt;
      wake_out_r <= wake_out_nxt;
      wake_oe_n_r <= wake_oe_n_nxt;
      irq_r <= irq_nxt;
    end
  end

  // The slave never stalls and never errors, so these are constant flops.
  logic hreadyout_r;
  logic hresp_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign wake_event_out = wake_out_r;
  assign wake_event_oe_n = wake_oe_n_r;
  assign irq_out = irq_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sleep_host_write;
    (pwr_r == RWC_SLEEP) && host_wr && !clr;
  endsequence

  sequence s_woken_locked;
    (pwr_r == RWC_RUN) && !read_seen_r && stat_r[IRQ_HOST_WAKE];
  endsequence

  a_hard_clear: assert property (!hard_s |=> (stat_r == IRQ_RESET) && !read_seen_r && (cfg_r == CFG_RESET))
    else $error("Hard reset pin did not clear state.");

  a_soft_clear: assert property (soft_reset_request_r |=> !soft_reset_request_r && (pwr_r == RWC_RUN) && (mask_r == IRQ_RESET))
    else $error("Soft reset did not clear state.");

  a_locked_write: assert property (wr_req && !read_seen_r && !clr |=> (cfg_r == $past(cfg_r)) && stat_r[IRQ_WR_DROP])
    else $error("Write took effect before first read.");

  a_read_unlock: assert property (rd_evt && !clr && !host_wake |=> read_seen_r)
    else $error("Read did not unlock writes.");

  a_wake_assert: assert property (cfg_r[CFG_WAKE_EN] && cfg_r[CFG_WAKE_POL] && !cfg_r[CFG_WAKE_OD]
      && stat_r[IRQ_WAKE_EVT] |-> wake_event_out && !wake_event_oe_n)
    else $error("Wake output not asserted for pending event.");

  a_od_release: assert property (cfg_r[CFG_WAKE_OD] |-> !wake_event_out)
    else $error("Open-drain wake output drove high.");

  a_event_no_wake: assert property ((pwr_r == RWC_SLEEP) && !host_wr && !clr |=> (pwr_r == RWC_SLEEP))
    else $error("Device left sleep without host write.");

  a_host_wake: assert property (s_sleep_host_write |=> s_woken_locked)
    else $error("Host write cycle did not wake and lock device.");

  a_irq_level: assert property (##1 (irq_out == |(stat_r & mask_r)))
    else $error("Interrupt output disagrees with masked status.");

endmodule : rwc_top
`default_nettype wire

// ### tb/rwc_host_model.sv
// Purpose: Host model issuing wake write cycles on the select and strobe pins.
// Assumes: Pins idle high between cycles.
// Notes: The hold length gives a prompt or a slow host.
`timescale 1ns/1ps
`default_nettype none
module rwc_host_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic [3:0] hold,
  output logic sel_n,
  output logic wr_n
);
  initial begin
    sel_n = 1'b1;
    wr_n = 1'b1;
    forever begin
      @(posedge hclk iff go);
      sel_n <= 1'b0;
      wr_n <= 1'b0;
      repeat (hold) @(posedge hclk);
      sel_n <= 1'b1;
      wr_n <= 1'b1;
    end
  end
endmodule : rwc_host_model
`default_nettype wire

// ### tb/rwc_top_tb.sv
// Purpose: Self-checking bench for the reset and wake control block.
// Assumes: Zero-wait AHB-Lite slave; pins held several cycles.
// Notes: Expected values queue up; one monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module rwc_top_tb;
  import rwc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hard_reset_in_n, wake_detect_in, go;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [3:0] hold;
  logic hreadyout, hresp, sel_n, wr_n, wake_event_out, wake_event_oe_n, irq_out, lvl;
  logic [31:0] exp_q[$], got_q[$];
  int fail_count, compares, cyc;

  rwc_top i_rwc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hard_reset_in_n(hard_reset_in_n), .host_select_n(sel_n),
    .host_write_strobe_n(wr_n), .wake_detect_in(wake_detect_in), .wake_event_out(wake_event_out),
    .wake_event_oe_n(wake_event_oe_n), .irq_out(irq_out));
  rwc_host_model i_rwc_host_model (.hclk(hclk), .go(go), .hold(hold), .sel_n(sel_n), .wr_n(wr_n));

  always #2.5 hclk = ~hclk;

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Single transfer; read data stands all through the data phase.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  // Both values queue up, so several notes in one time step are all compared.
  task automatic note(input logic [31:0] g, input logic [31:0] e);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : note

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, DATA_ZERO, r);
    note(r, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic evt();
    wake_detect_in <= 1'b1;
    repeat (4) @(posedge hclk);
    wake_detect_in <= 1'b0;
    repeat (8) @(posedge hclk);
    #1;
  endtask : evt

  task automatic wake_write();
    hold <= 4'h3 + 4'($urandom_range(0, 5));
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (14) @(posedge hclk);
  endtask : wake_write

  initial begin
    forever begin
      wait (got_q.size() > 0);
      check(got_q.pop_front(), exp_q.pop_front());
    end
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, hard_reset_in_n, wake_detect_in, go} = 7'b0000100;
    {haddr, hwdata, htrans, hold, cyc} = '0;
    hsize = HSIZE_WORD;
    void'($urandom(82535));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    note(wake_event_out, 1'b1);
    note(wake_event_oe_n, 1'b0);
    note(irq_out, 1'b0);
    note(hresp, 1'b0);
    wr(ADDR_CTRL, $urandom());
    rd(ADDR_CTRL, DATA_ZERO);
    rd(ADDR_IRQ_STAT, 32'h0000_0004);
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, 32'(c) << 4);
      rd(ADDR_CTRL, 32'(c) << 4);
      evt();
      lvl = c[0] ? c[1] : !c[1];
      note(c[2] ? wake_event_oe_n : wake_event_out, lvl);
      note(wake_event_out, c[2] ? 1'b0 : lvl);
      note(irq_out, 1'b1);
      wr(ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      #1;
      note(c[2] ? wake_event_oe_n : wake_event_out, !c[1]);
      note(irq_out, 1'b0);
    end
    wr(ADDR_IRQ_MASK, DATA_ZERO);
    evt();
    note(irq_out, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h0000_0001);
    wr(ADDR_IRQ_STAT, 32'h0000_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0002);
    rd(ADDR_STATE, 32'h0000_0003);
    evt();
    rd(ADDR_STATE, 32'h0000_0003);
    wake_write();
    #1;
    note(irq_out, 1'b1);
    wr(ADDR_IRQ_MASK, $urandom());
    rd(ADDR_IRQ_STAT, 32'h0000_0007);
    rd(ADDR_IRQ_MASK, 32'h0000_0002);
    wake_write();
    rd(ADDR_STATE, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0071);
    rd(ADDR_CTRL, DATA_ZERO);
    rd(ADDR_IRQ_MASK, DATA_ZERO);
    wr(ADDR_IRQ_MASK, 32'h0000_0005);
    hard_reset_in_n <= 1'b0;
    repeat (4) @(posedge hclk);
    hard_reset_in_n <= 1'b1;
    repeat (5) @(posedge hclk);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    rd(ADDR_IRQ_MASK, DATA_ZERO);
    rd(ADDR_IRQ_STAT, 32'h0000_0004);
    rd(ADDR_BYTE_TEST, BYTE_TEST_VAL);
    rd(8'h20, DATA_ZERO);
    repeat (2) @(posedge hclk);
    summarize();
  end
endmodule : rwc_top_tb
`default_nettype wire
